// ===== fdu_pkg.sv
// shared constants, state type and exponent helpers for the float divide unit
package fdu_pkg;

  localparam int WORD_W   = 60;
  localparam int COEF_W   = 48;
  localparam int EXPF_W   = 11;
  localparam int SIGN_BIT = 59;
  localparam int EXP_LSB  = 48;
  localparam int ITERS    = 24;
  localparam int PICKS    = ITERS + 1;
  localparam int QUO_W    = 2 * PICKS;
  localparam int REM_W    = COEF_W + 2;
  localparam int Q_TOP    = QUO_W - 1;
  localparam int Q_HIGH   = QUO_W - 2;

  // timing: clock period and quotient pick interval
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PICK_NS       = 100;
  localparam int PICK_CYC      = (PICK_NS * 1000) / CLK_PERIOD_PS;

  // exponent constants (octal 60, 57, 1777, 3777)
  localparam logic [EXPF_W-1:0] EXP_SUB_BASE = 11'h030;
  localparam logic [EXPF_W-1:0] EXP_SUB_NORM = 11'h02F;
  localparam logic [EXPF_W-1:0] EXP_INDEF    = 11'h3FF;
  localparam logic [EXPF_W-1:0] EXP_INF      = 11'h7FF;
  localparam logic [EXPF_W-1:0] EXP_BIAS_FLIP = 11'h400;
  localparam logic signed [12:0] EXP_OFF_VAL = 13'sh0030;
  localparam logic signed [12:0] EXP_MAX_VAL = 13'sh03FE;
  localparam logic signed [12:0] EXP_MIN_VAL = -13'sh03FE;
  localparam logic [12:0] EXP_POS_BASE = 13'h0400;
  localparam logic [12:0] EXP_NEG_BASE = 13'h03FF;

  typedef enum logic [1:0] {FDU_IDLE, FDU_RUN, FDU_PACK, FDU_DONE} fdu_state_t;

  // one's complement subtract by a subtractive adder: a - b gives +0 when equal
  function automatic logic [EXPF_W-1:0] oc_sub(input logic [EXPF_W-1:0] a, input logic [EXPF_W-1:0] b);
    logic [EXPF_W:0]   s;
    logic [EXPF_W-1:0] t;
    s = {1'b0, ~a} + {1'b0, b};
    t = s[EXPF_W-1:0] + {{(EXPF_W-1){1'b0}}, s[EXPF_W]};
    return ~t;
  endfunction : oc_sub

  // signed value of a biased exponent field, used for range checks
  function automatic logic signed [12:0] exp_val(input logic [EXPF_W-1:0] e);
    logic [12:0] base;
    base = e[EXPF_W-1] ? EXP_POS_BASE : EXP_NEG_BASE;
    return $signed({2'b00, e} - base);
  endfunction : exp_val

endpackage : fdu_pkg

// ===== fdu_trial_pick.sv
// three parallel trial subtractions and the 2-bit quotient pick
`timescale 1ns/1ps
module fdu_trial_pick #(
  parameter int W = fdu_pkg::REM_W
) (
  input  wire logic [W-1:0] rem,
  input  wire logic [W-1:0] mul1,
  input  wire logic [W-1:0] mul2,
  input  wire logic [W-1:0] mul3,
  output logic      [1:0]   pick,
  output logic      [W-1:0] diff
);

  logic [W:0] s1;
  logic [W:0] s2;
  logic [W:0] s3;

  // the extra top bit stands in for the end-around borrow of each network
  assign s1 = {1'b0, rem} - {1'b0, mul1};
  assign s2 = {1'b0, rem} - {1'b0, mul2};
  assign s3 = {1'b0, rem} - {1'b0, mul3};

  always_comb
  begin
    pick = 2'h0;
    diff = rem;
    if (!s3[W])
    begin
      pick = 2'h3;
      diff = s3[W-1:0];
    end
    else if (!s2[W])
    begin
      pick = 2'h2;
      diff = s2[W-1:0];
    end
    else if (!s1[W])
    begin
      pick = 2'h1;
      diff = s1[W-1:0];
    end
  end

endmodule : fdu_trial_pick

// ===== fdu_divide.sv
// floating point divide unit: coefficient divider, exponent path and result packing
`timescale 1ns/1ps
module fdu_divide #(
  parameter int PICK_CYC = fdu_pkg::PICK_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        go,
  input  wire logic                        round_mode,
  input  wire logic [fdu_pkg::WORD_W-1:0]  opnd_j,
  input  wire logic [fdu_pkg::WORD_W-1:0]  opnd_k,
  input  wire logic                        xmit,
  output logic                             busy,
  output logic                             done,
  output logic      [fdu_pkg::WORD_W-1:0]  result
);

  localparam int TW  = (PICK_CYC < 2) ? 1 : $clog2(PICK_CYC);
  localparam int LAT = PICK_CYC * fdu_pkg::PICKS + 2;
  localparam int CW  = fdu_pkg::COEF_W;
  localparam int RW  = fdu_pkg::REM_W;
  localparam int QW  = fdu_pkg::QUO_W;
  localparam int EW  = fdu_pkg::EXPF_W;

  // the spacing check counts in eight bits, so very long pick intervals are refused
  if (PICK_CYC < 2 || PICK_CYC > 200)
  begin : g_bad_pick
    $error("PICK_CYC must lie between 2 and 200");
  end

  fdu_pkg::fdu_state_t state_q, state_d;
  logic [TW-1:0]       tick_q, tick_d;
  logic [4:0]          pcnt_q, pcnt_d;
  logic [RW-1:0]       rem_q, rem_d;
  logic [RW-1:0]       m1_q, m1_d;
  logic [RW-1:0]       m2_q, m2_d;
  logic [RW-1:0]       m3_q, m3_d;
  logic [QW-1:0]       quo_q, quo_d;
  logic [EW-1:0]       e60_q, e60_d;
  logic [EW-1:0]       e57_q, e57_d;
  logic signed [12:0]  dval_q, dval_d;
  logic                sdiff_q, sdiff_d;
  logic                round_q, round_d;
  logic                norm_q, norm_d;
  logic [5:0]          flg_q, flg_d;
  logic [CW-1:0]       coefn_q, coefn_d;
  logic                spec_q, spec_d;
  logic                indef_q, indef_d;
  logic [fdu_pkg::WORD_W-1:0] res_q, res_d;
  logic [fdu_pkg::WORD_W-1:0] out_q, out_d;
  logic                done_q, done_d;

  // operand entry and start-of-divide arithmetic
  logic [fdu_pkg::WORD_W-1:0] jt;
  logic [fdu_pkg::WORD_W-1:0] kt;
  logic [EW-1:0]       ej;
  logic [EW-1:0]       ek;
  logic [EW-1:0]       ediff;
  logic                j_ind, j_inf, j_zero;
  logic                k_ind, k_inf, k_zero;

  assign jt = opnd_j[fdu_pkg::SIGN_BIT] ? ~opnd_j : opnd_j;
  assign kt = opnd_k[fdu_pkg::SIGN_BIT] ? ~opnd_k : opnd_k;
  assign ej = jt[fdu_pkg::EXP_LSB +: EW];
  assign ek = kt[fdu_pkg::EXP_LSB +: EW];
  // work on unbiased one's complement values by flipping the bias bit
  assign ediff = fdu_pkg::oc_sub(ej ^ fdu_pkg::EXP_BIAS_FLIP, ek ^ fdu_pkg::EXP_BIAS_FLIP);

  assign j_ind  = (ej == fdu_pkg::EXP_INDEF);
  assign j_inf  = (ej == fdu_pkg::EXP_INF);
  assign j_zero = (jt[CW-1:0] == '0);
  assign k_ind  = (ek == fdu_pkg::EXP_INDEF);
  assign k_inf  = (ek == fdu_pkg::EXP_INF);
  assign k_zero = (kt[CW-1:0] == '0);

  // quotient pick
  logic          pick_en;
  logic [1:0]    pick;
  logic [RW-1:0] tdiff;

  assign pick_en = (state_q == fdu_pkg::FDU_RUN) && (tick_q == TW'(PICK_CYC - 1));

  fdu_trial_pick #(
    .W (RW)
  ) fdu_trial_pick_i (
    .rem  (rem_q),
    .mul1 (m1_q),
    .mul2 (m2_q),
    .mul3 (m3_q),
    .pick (pick),
    .diff (tdiff)
  );

  // output stage
  logic               q48;
  logic [CW-1:0]      coef;
  logic [EW-1:0]      expn;
  logic signed [12:0] rval;
  logic               is_ind, is_inf, is_zero;
  logic [fdu_pkg::WORD_W-1:0] word;

  assign q48  = quo_q[fdu_pkg::Q_HIGH];
  assign coef = q48 ? quo_q[CW:1] : quo_q[CW-1:0];
  assign expn = q48 ? e57_q : e60_q;
  assign rval = dval_q - fdu_pkg::EXP_OFF_VAL + $signed({12'h000, q48});

  // flags: 5 j_ind, 4 j_inf, 3 j_zero, 2 k_ind, 1 k_inf, 0 k_zero
  assign is_ind  = flg_q[5] | flg_q[2] | (flg_q[4] & flg_q[1]) | (flg_q[3] & flg_q[0]);
  assign is_inf  = !is_ind && (flg_q[4] || flg_q[0] || (rval > fdu_pkg::EXP_MAX_VAL));
  assign is_zero = !is_ind && !is_inf && (flg_q[3] || flg_q[1] || (rval < fdu_pkg::EXP_MIN_VAL));

  // specials override after the sign complement, so they are always packed positive
  always_comb
  begin
    word = {1'b0, expn, coef};
    if (sdiff_q)
    begin
      word = ~word;
    end
    if (is_ind)
    begin
      word = {1'b0, fdu_pkg::EXP_INDEF, {CW{1'b0}}};
    end
    else if (is_inf)
    begin
      word = {1'b0, fdu_pkg::EXP_INF, {CW{1'b0}}};
    end
    else if (is_zero)
    begin
      word = '0;
    end
  end

  always_comb
  begin
    state_d = state_q;
    tick_d  = tick_q;
    pcnt_d  = pcnt_q;
    rem_d   = rem_q;
    m1_d    = m1_q;
    m2_d    = m2_q;
    m3_d    = m3_q;
    quo_d   = quo_q;
    e60_d   = e60_q;
    e57_d   = e57_q;
    dval_d  = dval_q;
    sdiff_d = sdiff_q;
    round_d = round_q;
    norm_d  = norm_q;
    flg_d   = flg_q;
    coefn_d = coefn_q;
    spec_d  = spec_q;
    indef_d = indef_q;
    res_d   = res_q;
    done_d  = 1'b0;
    // zero outside transmit lets several units share one result trunk
    out_d   = xmit ? res_q : '0;
    unique case (state_q)
      fdu_pkg::FDU_IDLE, fdu_pkg::FDU_DONE:
      begin
        if (go)
        begin
          state_d = fdu_pkg::FDU_RUN;
          tick_d  = '0;
          pcnt_d  = '0;
          quo_d   = '0;
          round_d = round_mode;
          rem_d   = {2'b00, jt[CW-1:1], jt[0] | round_mode};
          m1_d    = {2'b00, kt[CW-1:0]};
          m2_d    = {1'b0, kt[CW-1:0], 1'b0};
          m3_d    = {2'b00, kt[CW-1:0]} + {1'b0, kt[CW-1:0], 1'b0};
          e60_d   = fdu_pkg::oc_sub(ediff, fdu_pkg::EXP_SUB_BASE) ^ fdu_pkg::EXP_BIAS_FLIP;
          e57_d   = fdu_pkg::oc_sub(ediff, fdu_pkg::EXP_SUB_NORM) ^ fdu_pkg::EXP_BIAS_FLIP;
          dval_d  = fdu_pkg::exp_val(ej) - fdu_pkg::exp_val(ek);
          sdiff_d = opnd_j[fdu_pkg::SIGN_BIT] ^ opnd_k[fdu_pkg::SIGN_BIT];
          norm_d  = jt[CW-1] & kt[CW-1];
          flg_d   = {j_ind, j_inf, j_zero, k_ind, k_inf, k_zero};
        end
      end
      fdu_pkg::FDU_RUN:
      begin
        tick_d = tick_q + 1'b1;
        if (pick_en)
        begin
          // one clock drives both picks and shifts, so the catch-up stages are not needed
          tick_d = '0;
          quo_d  = {quo_q[QW-3:0], pick};
          // the remainder stays below the divisor, so its top two bits are always zero
          rem_d  = {tdiff[CW-1:0], 1'b0, round_q};
          pcnt_d = pcnt_q + 5'h01;
          if (pcnt_q == 5'(fdu_pkg::PICKS - 1))
          begin
            state_d = fdu_pkg::FDU_PACK;
          end
        end
      end
      fdu_pkg::FDU_PACK:
      begin
        res_d   = word;
        coefn_d = coef;
        spec_d  = is_ind | is_inf | is_zero;
        indef_d = is_ind;
        done_d  = 1'b1;
        state_d = fdu_pkg::FDU_DONE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= fdu_pkg::FDU_IDLE;
      tick_q  <= '0;
      pcnt_q  <= '0;
      rem_q   <= '0;
      m1_q    <= '0;
      m2_q    <= '0;
      m3_q    <= '0;
      quo_q   <= '0;
      e60_q   <= '0;
      e57_q   <= '0;
      dval_q  <= '0;
      sdiff_q <= 1'b0;
      round_q <= 1'b0;
      norm_q  <= 1'b0;
      flg_q   <= '0;
      coefn_q <= '0;
      spec_q  <= 1'b0;
      indef_q <= 1'b0;
      res_q   <= '0;
      out_q   <= '0;
      done_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tick_q  <= tick_d;
      pcnt_q  <= pcnt_d;
      rem_q   <= rem_d;
      m1_q    <= m1_d;
      m2_q    <= m2_d;
      m3_q    <= m3_d;
      quo_q   <= quo_d;
      e60_q   <= e60_d;
      e57_q   <= e57_d;
      dval_q  <= dval_d;
      sdiff_q <= sdiff_d;
      round_q <= round_d;
      norm_q  <= norm_d;
      flg_q   <= flg_d;
      coefn_q <= coefn_d;
      spec_q  <= spec_d;
      indef_q <= indef_d;
      res_q   <= res_d;
      out_q   <= out_d;
      done_q  <= done_d;
    end
  end

  assign busy   = (state_q == fdu_pkg::FDU_RUN) || (state_q == fdu_pkg::FDU_PACK);
  assign done   = done_q;
  assign result = out_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic start;
  assign start = go && !busy;

  // cycles since the last pick, for the spacing check below
  logic [7:0] gap_q, gap_d;

  always_comb
  begin
    gap_d = gap_q;
    if (pick_en)
    begin
      gap_d = 8'h01;
    end
    else if (gap_q != 8'hFF)
    begin
      gap_d = gap_q + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap_q <= 8'hFF;
    end
    else
    begin
      gap_q <= gap_d;
    end
  end

  chk_done_latency: assert property (start |-> ##[LAT:LAT] done)
    else $error("done not seen at the expected cycle after go");
  chk_pick_spacing: assert property (pick_en && pcnt_q != 5'h00 |-> gap_q == 8'(PICK_CYC))
    else $error("quotient picks not one pick interval apart");
  chk_quo_shift: assert property (pick_en |=> quo_q == {$past(quo_q[QW-3:0]), $past(pick)})
    else $error("quotient register did not shift in the pick");
  chk_first_pick: assert property (pick_en && pcnt_q == 5'h00 && norm_q |-> !pick[1])
    else $error("first pick above 01 with normalized operands");
  chk_second_pick: assert property (pick_en && pcnt_q == 5'h01 && norm_q && quo_q[1:0] == 2'h0 |-> pick[1])
    else $error("second pick below 10 after a 00 first pick");
  chk_quo_top: assert property (state_q == fdu_pkg::FDU_PACK && norm_q |-> !quo_q[fdu_pkg::Q_TOP] && (quo_q[48] || quo_q[47]))
    else $error("normalized quotient has bad top bits");
  chk_norm_coef: assert property (done && norm_q && !spec_q |-> coefn_q[CW-1])
    else $error("packed coefficient is not normalized");
  chk_xmit_gate: assert property (!xmit |=> result == '0)
    else $error("result driven without transmit");
  chk_sign_cmpl: assert property (xmit && state_q == fdu_pkg::FDU_DONE && !spec_q && sdiff_q
                                  |=> result[CW-1:0] == ~$past(coefn_q))
    else $error("negative quotient coefficient not complemented");
  chk_special_zero: assert property (xmit && state_q == fdu_pkg::FDU_DONE && spec_q |=> result[CW-1:0] == '0)
    else $error("special result with nonzero coefficient");
  chk_indef_pack: assert property (xmit && state_q == fdu_pkg::FDU_DONE && indef_q
                                   |=> result[fdu_pkg::EXP_LSB +: EW] == fdu_pkg::EXP_INDEF)
    else $error("indefinite result has wrong exponent");
  chk_special_pack: assert property (xmit && state_q == fdu_pkg::FDU_DONE && spec_q && !indef_q
                                     |=> result == {1'b0, fdu_pkg::EXP_INF, {CW{1'b0}}} || result == '0)
    else $error("infinite or zero result packed wrongly");
  chk_exp_pair: assert property (busy |-> (fdu_pkg::oc_sub(e57_q ^ fdu_pkg::EXP_BIAS_FLIP, 11'h001)
                                 ^ fdu_pkg::EXP_BIAS_FLIP) == e60_q)
    else $error("exponent candidates do not differ by one");

  cov_normal: cover property (done && !spec_q && !sdiff_q);
  cov_negative: cover property (done && !spec_q && sdiff_q);
  cov_indef: cover property (done && indef_q);
  cov_round: cover property (start && round_mode ##[LAT:LAT] done);
  cov_first_zero: cover property (pick_en && pcnt_q == 5'h01 && norm_q && quo_q[1:0] == 2'h0);

endmodule : fdu_divide

// ===== fdu_score.sv
// scoreboard and shared operand register model on the far side of the divide unit
`timescale 1ns/1ps
module fdu_score (
  input  wire logic        clk,
  input  wire logic        done,
  input  wire logic [59:0] result,
  output logic             go,
  output logic             round_mode,
  output logic      [59:0] opnd_j,
  output logic      [59:0] opnd_k,
  output logic             xmit
);
  initial
  begin
    go         = 1'b0;
    round_mode = 1'b0;
    opnd_j     = 60'h0;
    opnd_k     = 60'h0;
    xmit       = 1'b0;
  end

  // call at a falling edge; the shared registers move on after the go cycle, so stale operands are lost
  task issue(input logic [59:0] j, input logic [59:0] k, input logic r);
    go         = 1'b1;
    opnd_j     = j;
    opnd_k     = k;
    round_mode = r;
    @(negedge clk);
    go         = 1'b0;
    opnd_j     = ~j;
    opnd_k     = ~k;
    round_mode = ~r;
  endtask : issue

  task wait_done(output int lat);
    lat = 1;
    while (done !== 1'b1 && lat < 400)
    begin
      @(negedge clk);
      lat++;
    end
  endtask : wait_done

  // transmit raised once the result is due, for one cycle
  task take(output logic [59:0] w);
    xmit = 1'b1;
    @(negedge clk);
    xmit = 1'b0;
    w    = result;
  endtask : take
endmodule : fdu_score

// ===== fdu_divide_tb_top.sv
// self-checking bench for the float divide unit
`timescale 1ns/1ps
module fdu_divide_tb_top;
  localparam int          PCYC = 4;
  localparam int          LAT  = PCYC * 25 + 2;
  localparam logic [47:0] CA   = 48'hAAAAAAAAAAAA;
  localparam logic [47:0] CB   = 48'h800000000000;
  localparam logic [59:0] OA   = {1'b0, 11'h400, CA};
  localparam logic [59:0] OB   = {1'b0, 11'h400, CB};
  localparam logic [59:0] OC   = {1'b0, 11'h410, CB};
  localparam logic [59:0] OD   = {1'b0, 11'h3F0, 48'hFFFFFFFFFFFF};
  localparam logic [59:0] OE   = {1'b0, 11'h401, 48'hC00000000001};
  localparam logic [59:0] OF   = {1'b0, 11'h3FE, 48'h9234567890AB};
  logic        clk;
  logic        sys_rst;
  logic        go;
  logic        round_mode;
  logic [59:0] opnd_j;
  logic [59:0] opnd_k;
  logic        xmit;
  logic        busy;
  logic        done;
  logic [59:0] result;
  int          failures;
  int          tests_run;
  logic [59:0] w;
  int          lat;

  fdu_divide #(.PICK_CYC(PCYC)) fdu_divide_i (.clk(clk), .sys_rst(sys_rst), .go(go), .round_mode(round_mode),
    .opnd_j(opnd_j), .opnd_k(opnd_k), .xmit(xmit), .busy(busy), .done(done), .result(result));
  fdu_score fdu_score_i (.clk(clk), .done(done), .result(result), .go(go), .round_mode(round_mode),
    .opnd_j(opnd_j), .opnd_k(opnd_k), .xmit(xmit));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [59:0] fw(input logic [10:0] e, input logic [47:0] c);
    return {1'b0, e, c};
  endfunction : fw

  function automatic int ev(input logic [10:0] e);
    return e[10] ? int'(e) - 1024 : int'(e) - 1023;
  endfunction : ev

  // expected word: specials first, then long division with optional one-third rounding
  function automatic logic [59:0] model(input logic [59:0] j, input logic [59:0] k, input logic r);
    logic [59:0] a;
    logic [59:0] b;
    logic [95:0] num;
    logic [49:0] q;
    int          ve;
    logic [59:0] wd;
    a = j[59] ? ~j : j;
    b = k[59] ? ~k : k;
    if (a[58:48] == 11'h3FF || b[58:48] == 11'h3FF || (a[58:48] == 11'h7FF && b[58:48] == 11'h7FF)
        || (a[47:0] == 48'h0 && b[47:0] == 48'h0))
      return fw(11'h3FF, 48'h0);
    if (a[58:48] == 11'h7FF || b[47:0] == 48'h0)
      return fw(11'h7FF, 48'h0);
    if (a[47:0] == 48'h0 || b[58:48] == 11'h7FF)
      return 60'h0;
    num = {48'h0, a[47:1], a[0] | r} << 48;
    num = num + (r ? 96'h555555555555 : 96'h0);
    q   = 50'(num / {48'h0, b[47:0]});
    ve  = ev(a[58:48]) - ev(b[58:48]) - (q[48] ? 47 : 48);
    if (ve > 1022)
      return fw(11'h7FF, 48'h0);
    if (ve < -1022)
      return 60'h0;
    wd = fw(11'(ve + (ve < 0 ? 1023 : 1024)), q[48] ? q[48:1] : q[47:0]);
    return (j[59] ^ k[59]) ? ~wd : wd;
  endfunction : model

  task chk(input logic [59:0] got, input logic [59:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task run1(input logic [59:0] j, input logic [59:0] k, input logic r);
    fdu_score_i.issue(j, k, r);
    fdu_score_i.wait_done(lat);
    chk(60'(lat), 60'(LAT));
    fdu_score_i.take(w);
    chk(w, model(j, k, r));
  endtask : run1

  task t_normal;
    run1(OA, OB, 1'b0);
    run1(OA, OB, 1'b1);
    run1(~OA, OB, 1'b0);
    run1(~OA, ~OB, 1'b0);
    run1(OC, OD, 1'b0);
    run1(OE, OF, 1'b1);
  endtask : t_normal

  task t_special;
    run1(fw(11'h7FF, CA), OB, 1'b0);
    run1(fw(11'h3FF, CA), OB, 1'b0);
    run1(OA, fw(11'h3FF, CB), 1'b0);
    run1(fw(11'h400, 48'h0), OB, 1'b0);
    run1(OA, fw(11'h400, 48'h0), 1'b0);
    run1(OA, fw(11'h7FF, CB), 1'b0);
    run1(fw(11'h7FF, CA), fw(11'h7FF, CB), 1'b0);
    run1(fw(11'h400, 48'h0), fw(11'h400, 48'h0), 1'b0);
    run1(fw(11'h7E8, CA), fw(11'h3A0, CB), 1'b0);
    run1(fw(11'h017, CA), fw(11'h464, CB), 1'b0);
    run1(~fw(11'h7FF, CA), OB, 1'b0);
  endtask : t_special

  task t_gate;
    fdu_score_i.issue(OA, OB, 1'b0);
    fdu_score_i.wait_done(lat);
    repeat (3)
    begin
      @(negedge clk);
      chk(result, 60'h0);
    end
    fdu_score_i.take(w);
    chk(w, model(OA, OB, 1'b0));
    @(negedge clk);
    chk(result, 60'h0);
  endtask : t_gate

  // a go while busy is dropped; a go in the done cycle starts at once while the old word stays readable
  task t_order;
    fdu_score_i.issue(OA, OB, 1'b0);
    repeat (10) @(negedge clk);
    chk({59'h0, busy}, 60'h1);
    fdu_score_i.issue(OC, OD, 1'b0);
    fdu_score_i.wait_done(lat);
    chk(60'(lat), 60'(LAT - 11));
    fdu_score_i.issue(OE, OF, 1'b0);
    fdu_score_i.take(w);
    chk(w, model(OA, OB, 1'b0));
    // the take above used one cycle of the new divide
    fdu_score_i.wait_done(lat);
    chk(60'(lat), 60'(LAT - 1));
    fdu_score_i.take(w);
    chk(w, model(OE, OF, 1'b0));
  endtask : t_order

  task t_reset;
    fdu_score_i.issue(OA, OB, 1'b0);
    repeat (20) @(negedge clk);
    sys_rst = 1'b1;
    @(negedge clk);
    chk({58'h0, busy, done}, 60'h0);
    chk(result, 60'h0);
    sys_rst = 1'b0;
    run1(OC, OD, 1'b0);
  endtask : t_reset

  task test_done;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    failures  = 0;
    tests_run = 0;
    sys_rst   = 1'b1;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    t_normal();
    t_special();
    t_gate();
    t_order();
    t_reset();
    test_done();
  end

  // about 22 divides are run; allow about four times that
  initial
  begin
    #(25 * 90 * LAT);
    failures++;
    test_done();
  end
endmodule : fdu_divide_tb_top
